// *** pkg/cca_pkg.sv ***
/*
 Constants, register map and carrier types of the calendar clock.
 Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
*/
`default_nettype none
package cca_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_TIME  = 8'h04;
   localparam logic [7:0] A_CAL   = 8'h08;
   localparam logic [7:0] A_ATIME = 8'h0C;
   localparam logic [7:0] A_ACAL  = 8'h10;
   localparam logic [7:0] A_AEN   = 8'h14;
   localparam logic [7:0] A_IEN   = 8'h18;
   localparam logic [7:0] A_IDIS  = 8'h1C;
   localparam logic [7:0] A_IMSK  = 8'h20;
   localparam logic [7:0] A_EVT   = 8'h24;
   localparam logic [7:0] A_KEEP  = 8'h28;
   localparam logic [7:0] A_DIV   = 8'h2C;
   localparam logic [7:0] A_DEN   = 8'h30;
   localparam logic [7:0] A_WPER  = 8'h34;
   localparam logic [7:0] A_WCTL  = 8'h38;
   localparam logic [7:0] A_WCNT  = 8'h3C;
   localparam logic [7:0] A_WCLR  = 8'h40;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int C_TDIS = 0;
   localparam int C_CDIS = 1;
   localparam int C_H12  = 2;
   localparam logic [2:0] CTRL_RST = 3'h3;
   localparam int PM_BIT = 24;
   localparam int FW     = 24;
   localparam int NAE    = 6;
   localparam int AE_REC = 6;
   localparam int NEV    = 9;
   localparam int E_SEC  = 0;
   localparam int E_MIN  = 1;
   localparam int E_HOUR = 2;
   localparam int E_HALF = 3;
   localparam int E_DAY  = 4;
   localparam int E_WEEK = 5;
   localparam int E_MON  = 6;
   localparam int E_YEAR = 7;
   localparam int E_ALM  = 8;
   localparam int DI_W   = 13;
   localparam int DF_LSB = 13;
   localparam int DF_W   = 10;
   localparam int D_EN   = 31;
   localparam int WP_W   = 13;
   // ----------------------------------------
   // Field limits
   // ----------------------------------------
   localparam logic [6:0] HUND_MAX = 7'h63;
   localparam logic [5:0] MS_MAX   = 6'h3B;
   localparam logic [4:0] HR_MAX   = 5'h17;
   localparam logic [4:0] HR_HALF  = 5'h0C;
   localparam logic [2:0] WD_MIN   = 3'h1;
   localparam logic [2:0] WD_MAX   = 3'h7;
   localparam logic [4:0] DT_MIN   = 5'h01;
   localparam logic [3:0] MON_MIN  = 4'h1;
   localparam logic [3:0] MON_MAX  = 4'hC;
   localparam logic [3:0] MON_FEB  = 4'h2;
   localparam logic [6:0] YR_MAX   = 7'h63;
   localparam logic [4:0] CEN_MIN  = 5'h13;
   localparam logic [4:0] CEN_MAX  = 5'h1D;
   localparam logic [4:0] D28      = 5'h1C;
   localparam logic [4:0] D29      = 5'h1D;
   localparam logic [4:0] D30      = 5'h1E;
   localparam logic [4:0] D31      = 5'h1F;
   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [4:0] hour;
      logic [5:0] min;
      logic [5:0] sec;
      logic [6:0] hund;
   } cca_time_t;
   typedef struct packed {
      logic [4:0] cent;
      logic [6:0] year;
      logic [3:0] month;
      logic [4:0] date;
      logic [2:0] wday;
   } cca_cal_t;
   localparam cca_cal_t CAL_RST = '{cent: CEN_MIN, year: 7'h00, month: MON_MIN,
                                    date: DT_MIN, wday: WD_MIN};
endpackage
`default_nettype wire

// *** src/cca_rtc.sv ***
/*
 Calendar clock with alarm, rollover events, wake countdown and 100 Hz
 fractional divider, behind an AHB-Lite slave.
 Assumes a same-clock software reset request and a free low-power clock pin.
*/
// Added by the designer: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module cca_rtc #(
   parameter logic [12:0] DIV_INT_RST  = 13'h0147,
   parameter logic [9:0]  DIV_FRAC_RST = 10'h2A8,
   parameter logic [9:0]  DIV_DEN_RST  = 10'h3E8
) (
   // Clock, reset, enable
   input  wire logic        CLK_IN,
   input  wire logic        ARST_N_IN,
   input  wire logic        CE_IN,
   // Low-power clock pin and software reset request
   input  wire logic        LP_CLK_IN,
   input  wire logic        SW_RESET_IN,
   // AHB-Lite slave
   input  wire logic        HSEL_IN,
   input  wire logic [31:0] HADDR_IN,
   input  wire logic [1:0]  HTRANS_IN,
   input  wire logic        HWRITE_IN,
   input  wire logic [2:0]  HSIZE_IN,
   input  wire logic [31:0] HWDATA_IN,
   input  wire logic        HREADY_IN,
   output logic      [31:0] HRDATA_OUT,
   output logic             HREADYOUT_OUT,
   output logic             HRESP_OUT,
   // Wake and interrupt lines
   output logic             WAKE_EVENT_OUT,
   output logic             WAKE_IRQ_OUT,
   output logic             RTC_IRQ_OUT
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   cca_pkg::cca_time_t   time_reg, t_next, atime_reg;
   cca_pkg::cca_cal_t    cal_reg, c_next, acal_reg;
   logic [2:0]           ctrl_reg;
   logic                 keep_reg;
   logic [cca_pkg::NAE:0] aen_reg;
   logic [cca_pkg::NEV-1:0] ien_reg, evt_reg, ev;
   logic [12:0]          dint_reg, dcnt_reg;
   logic [9:0]           dfrac_reg, dden_reg;
   logic [10:0]          dacc_reg, acc_sum;
   logic                 den_reg, dext_reg;
   logic [12:0]          wper_reg, wcnt_reg;
   logic                 wen_reg, wflag_reg;
   logic                 lp_s1_reg, lp_s2_reg, lp_s3_reg, lp_lvl_reg, lp_rise;
   logic                 tick, adv, adv_reg, day_c, leap, alm_hit, clr;
   logic                 wr_reg, rd_reg, hready_reg, req;
   logic [7:0]           wa_reg, ra_reg;
   logic [31:0]          hrdata_reg, rdata;
   logic                 irq_reg;
   logic                 wr_ctrl, wr_time, wr_cal, wr_at, wr_ac, wr_aen, wr_evt;
   logic                 rd_evt, rd_wclr;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [4:0] dim(input logic [3:0] m, input logic lp);
      case (m)
         cca_pkg::MON_FEB: dim = lp ? cca_pkg::D29 : cca_pkg::D28;
         4'h4, 4'h6, 4'h9, 4'hB: dim = cca_pkg::D30;
         default: dim = cca_pkg::D31;
      endcase
   endfunction

   function automatic logic [5:0] to12(input logic [4:0] h);
      logic [4:0] hh;
      hh = (h >= cca_pkg::HR_HALF) ? h - cca_pkg::HR_HALF : h;
      to12 = {h >= cca_pkg::HR_HALF, (hh == 5'h00) ? cca_pkg::HR_HALF : hh};
   endfunction

   function automatic logic [31:0] rd_time(input cca_pkg::cca_time_t t, input logic h12);
      logic [5:0] c;
      c = to12(t.hour);
      rd_time = {7'h00, h12 & c[5], h12 ? c[4:0] : t.hour, t.min, t.sec, t.hund};
   endfunction

   function automatic cca_pkg::cca_time_t wr_tm(input logic [31:0] w, input logic h12);
      logic [4:0] hh;
      wr_tm = cca_pkg::cca_time_t'(w[cca_pkg::FW-1:0]);
      hh = (wr_tm.hour == cca_pkg::HR_HALF) ? 5'h00 : wr_tm.hour;
      if (h12)
         wr_tm.hour = w[cca_pkg::PM_BIT] ? hh + cca_pkg::HR_HALF : hh;
   endfunction

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   // Reads take one wait state so a write just before is already visible
   assign req = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
      begin
         wr_reg     <= 1'b0;
         rd_reg     <= 1'b0;
         wa_reg     <= 8'h00;
         ra_reg     <= 8'h00;
         hready_reg <= 1'b1;
         hrdata_reg <= 32'h00000000;
      end
      else if (CE_IN)
      begin
         wr_reg     <= req & HWRITE_IN;
         rd_reg     <= req & ~HWRITE_IN;
         hready_reg <= ~(req & ~HWRITE_IN);
         if (req)
         begin
            wa_reg <= {HADDR_IN[7:2], 2'b00};
            ra_reg <= {HADDR_IN[7:2], 2'b00};
         end
         if (rd_reg)
            hrdata_reg <= rdata;
      end

   assign wr_ctrl = wr_reg && wa_reg == cca_pkg::A_CTRL;
   assign wr_time = wr_reg && wa_reg == cca_pkg::A_TIME;
   assign wr_cal  = wr_reg && wa_reg == cca_pkg::A_CAL;
   assign wr_at   = wr_reg && wa_reg == cca_pkg::A_ATIME;
   assign wr_ac   = wr_reg && wa_reg == cca_pkg::A_ACAL;
   assign wr_aen  = wr_reg && wa_reg == cca_pkg::A_AEN;
   assign wr_evt  = wr_reg && wa_reg == cca_pkg::A_EVT;
   assign rd_evt  = rd_reg && ra_reg == cca_pkg::A_EVT;
   assign rd_wclr = rd_reg && ra_reg == cca_pkg::A_WCLR;

   always_comb
   begin
      case (ra_reg)
         cca_pkg::A_CTRL:  rdata = {29'h0, ctrl_reg};
         cca_pkg::A_TIME:  rdata = rd_time(time_reg, ctrl_reg[cca_pkg::C_H12]);
         cca_pkg::A_CAL:   rdata = {8'h00, cal_reg};
         cca_pkg::A_ATIME: rdata = rd_time(atime_reg, ctrl_reg[cca_pkg::C_H12]);
         cca_pkg::A_ACAL:  rdata = {8'h00, acal_reg};
         cca_pkg::A_AEN:   rdata = {25'h0, aen_reg};
         cca_pkg::A_IMSK:  rdata = {23'h0, ien_reg};
         cca_pkg::A_EVT:   rdata = {23'h0, evt_reg};
         cca_pkg::A_KEEP:  rdata = {31'h0, keep_reg};
         cca_pkg::A_DIV:   rdata = {den_reg, 8'h00, dfrac_reg, dint_reg};
         cca_pkg::A_DEN:   rdata = {22'h0, dden_reg};
         cca_pkg::A_WPER:  rdata = {19'h0, wper_reg};
         cca_pkg::A_WCTL:  rdata = {31'h0, wen_reg};
         cca_pkg::A_WCNT:  rdata = {19'h0, wcnt_reg};
         cca_pkg::A_WCLR:  rdata = {31'h0, wflag_reg};
         default:          rdata = 32'h00000000;
      endcase
   end

   // ----------------------------------------
   // Control and keep
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
      begin
         ctrl_reg <= cca_pkg::CTRL_RST;
         keep_reg <= 1'b0;
      end
      else if (CE_IN)
      begin
         if (wr_ctrl)
            ctrl_reg <= HWDATA_IN[2:0];
         if (wr_reg && wa_reg == cca_pkg::A_KEEP)
            keep_reg <= HWDATA_IN[0];
      end

   assign clr = SW_RESET_IN & ~keep_reg;

   // ----------------------------------------
   // Low-power clock and tick divider
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
      begin
         lp_s1_reg  <= 1'b0;
         lp_s2_reg  <= 1'b0;
         lp_s3_reg  <= 1'b0;
         lp_lvl_reg <= 1'b0;
      end
      else if (CE_IN)
      begin
         lp_s1_reg <= LP_CLK_IN;
         lp_s2_reg <= lp_s1_reg;
         lp_s3_reg <= lp_s2_reg;
         if (lp_s2_reg == lp_s3_reg)
            lp_lvl_reg <= lp_s3_reg;
      end

   assign lp_rise = lp_s2_reg & lp_s3_reg & ~lp_lvl_reg;
   // Period is the integer part, stretched by one edge on each fraction carry
   assign tick    = den_reg & lp_rise & (14'(dcnt_reg) + 14'h0001 >= 14'(dint_reg) + 14'(dext_reg));
   assign acc_sum = dacc_reg + 11'(dfrac_reg);

   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
      begin
         dint_reg  <= DIV_INT_RST;
         dfrac_reg <= DIV_FRAC_RST;
         dden_reg  <= DIV_DEN_RST;
         den_reg   <= 1'b0;
      end
      else if (CE_IN)
      begin
         if (wr_reg && wa_reg == cca_pkg::A_DIV)
         begin
            dint_reg  <= HWDATA_IN[cca_pkg::DI_W-1:0];
            dfrac_reg <= HWDATA_IN[cca_pkg::DF_LSB+cca_pkg::DF_W-1:cca_pkg::DF_LSB];
            den_reg   <= HWDATA_IN[cca_pkg::D_EN];
         end
         if (wr_reg && wa_reg == cca_pkg::A_DEN)
            dden_reg <= HWDATA_IN[cca_pkg::DF_W-1:0];
      end

   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
      begin
         dcnt_reg <= 13'h0000;
         dacc_reg <= 11'h000;
         dext_reg <= 1'b0;
      end
      else if (CE_IN)
      begin
         if (!den_reg || clr)
         begin
            dcnt_reg <= 13'h0000;
            dacc_reg <= 11'h000;
            dext_reg <= 1'b0;
         end
         else if (tick)
         begin
            dcnt_reg <= 13'h0000;
            if (acc_sum >= 11'(dden_reg))
            begin
               dacc_reg <= acc_sum - 11'(dden_reg);
               dext_reg <= 1'b1;
            end
            else
            begin
               dacc_reg <= acc_sum;
               dext_reg <= 1'b0;
            end
         end
         else if (lp_rise)
            dcnt_reg <= dcnt_reg + 13'h0001;
      end

   // ----------------------------------------
   // Time and calendar counting
   // ----------------------------------------
   assign adv  = tick & ~ctrl_reg[cca_pkg::C_TDIS];
   assign leap = (cal_reg.year[1:0] == 2'b00) &
                 ((cal_reg.year != 7'h00) | (cal_reg.cent[1:0] == 2'b00));

   always_comb
   begin
      t_next = time_reg;
      c_next = cal_reg;
      ev     = '0;
      day_c  = 1'b0;
      if (adv)
      begin
         if (time_reg.hund != cca_pkg::HUND_MAX)
            t_next.hund = time_reg.hund + 7'h01;
         else
         begin
            t_next.hund   = 7'h00;
            ev[cca_pkg::E_SEC] = 1'b1;
            if (time_reg.sec != cca_pkg::MS_MAX)
               t_next.sec = time_reg.sec + 6'h01;
            else
            begin
               t_next.sec = 6'h00;
               ev[cca_pkg::E_MIN] = 1'b1;
               if (time_reg.min != cca_pkg::MS_MAX)
                  t_next.min = time_reg.min + 6'h01;
               else
               begin
                  t_next.min = 6'h00;
                  ev[cca_pkg::E_HOUR] = 1'b1;
                  if (time_reg.hour != cca_pkg::HR_MAX)
                     t_next.hour = time_reg.hour + 5'h01;
                  else
                  begin
                     t_next.hour = 5'h00;
                     day_c = 1'b1;
                     ev[cca_pkg::E_DAY] = 1'b1;
                  end
                  ev[cca_pkg::E_HALF] = ctrl_reg[cca_pkg::C_H12] &
                     (t_next.hour == 5'h00 || t_next.hour == cca_pkg::HR_HALF);
               end
            end
         end
      end
      if (day_c && !ctrl_reg[cca_pkg::C_CDIS])
      begin
         if (cal_reg.wday != cca_pkg::WD_MAX)
            c_next.wday = cal_reg.wday + 3'h1;
         else
         begin
            c_next.wday = cca_pkg::WD_MIN;
            ev[cca_pkg::E_WEEK] = 1'b1;
         end
         if (cal_reg.date < dim(cal_reg.month, leap))
            c_next.date = cal_reg.date + 5'h01;
         else
         begin
            c_next.date = cca_pkg::DT_MIN;
            ev[cca_pkg::E_MON] = 1'b1;
            if (cal_reg.month < cca_pkg::MON_MAX)
               c_next.month = cal_reg.month + 4'h1;
            else
            begin
               c_next.month = cca_pkg::MON_MIN;
               ev[cca_pkg::E_YEAR] = 1'b1;
               if (cal_reg.year < cca_pkg::YR_MAX)
                  c_next.year = cal_reg.year + 7'h01;
               else
               begin
                  c_next.year = 7'h00;
                  // Past 2999 the count wraps to 1900
                  c_next.cent = (cal_reg.cent >= cca_pkg::CEN_MAX) ?
                                cca_pkg::CEN_MIN : cal_reg.cent + 5'h01;
               end
            end
         end
      end
      ev[cca_pkg::E_ALM] = alm_hit;
   end

   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
      begin
         time_reg <= '0;
         cal_reg  <= cca_pkg::CAL_RST;
         adv_reg  <= 1'b0;
      end
      else if (CE_IN)
      begin
         adv_reg <= adv & ~clr;
         if (clr)
         begin
            time_reg <= '0;
            cal_reg  <= cca_pkg::CAL_RST;
         end
         else
         begin
            time_reg <= wr_time ? wr_tm(HWDATA_IN, ctrl_reg[cca_pkg::C_H12]) : t_next;
            cal_reg  <= wr_cal ? cca_pkg::cca_cal_t'(HWDATA_IN[cca_pkg::FW-1:0]) : c_next;
         end
      end

   // ----------------------------------------
   // Alarm
   // ----------------------------------------
   // Compared once per advance, so a match fires once, not for 10 ms
   assign alm_hit = adv_reg & (|aen_reg[cca_pkg::NAE-1:0]) &
                    (!aen_reg[0] || time_reg.hund == atime_reg.hund) &
                    (!aen_reg[1] || time_reg.sec == atime_reg.sec) &
                    (!aen_reg[2] || time_reg.min == atime_reg.min) &
                    (!aen_reg[3] || time_reg.hour == atime_reg.hour) &
                    (!aen_reg[4] || cal_reg.date == acal_reg.date) &
                    (!aen_reg[5] || cal_reg.month == acal_reg.month);

   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
      begin
         atime_reg <= '0;
         acal_reg  <= cca_pkg::CAL_RST;
         aen_reg   <= '0;
      end
      else if (CE_IN)
      begin
         if (wr_at)
            atime_reg <= wr_tm(HWDATA_IN, ctrl_reg[cca_pkg::C_H12]);
         if (wr_ac)
            acal_reg <= cca_pkg::cca_cal_t'(HWDATA_IN[cca_pkg::FW-1:0]);
         if (wr_aen)
            aen_reg <= HWDATA_IN[cca_pkg::NAE:0];
         else if (alm_hit && !aen_reg[cca_pkg::AE_REC])
            aen_reg[cca_pkg::NAE-1:0] <= '0;
      end

   // ----------------------------------------
   // Event flags and interrupt
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
      begin
         evt_reg <= '0;
         ien_reg <= '0;
         irq_reg <= 1'b0;
      end
      else if (CE_IN)
      begin
         // Hardware set wins over the read that clears
         evt_reg <= clr ? '0 : ((evt_reg & ~{cca_pkg::NEV{rd_evt}}) | ev |
                    (wr_evt ? HWDATA_IN[cca_pkg::NEV-1:0] : '0));
         if (wr_reg && wa_reg == cca_pkg::A_IEN)
            ien_reg <= ien_reg | HWDATA_IN[cca_pkg::NEV-1:0];
         else if (wr_reg && wa_reg == cca_pkg::A_IDIS)
            ien_reg <= ien_reg & ~HWDATA_IN[cca_pkg::NEV-1:0];
         irq_reg <= |(evt_reg & ien_reg);
      end

   // ----------------------------------------
   // Wake countdown
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
      begin
         wper_reg  <= '0;
         wcnt_reg  <= '0;
         wen_reg   <= 1'b0;
         wflag_reg <= 1'b0;
      end
      else if (CE_IN)
      begin
         if (wr_reg && wa_reg == cca_pkg::A_WCTL)
            wen_reg <= HWDATA_IN[0];
         if (wr_reg && wa_reg == cca_pkg::A_WPER)
         begin
            wper_reg <= HWDATA_IN[cca_pkg::WP_W-1:0];
            wcnt_reg <= HWDATA_IN[cca_pkg::WP_W-1:0];
         end
         else if (wen_reg && tick)
            wcnt_reg <= (wcnt_reg == 13'h0000) ? wper_reg : wcnt_reg - 13'h0001;
         if (wen_reg && tick && wcnt_reg == 13'h0001)
            wflag_reg <= 1'b1;
         else if (rd_wclr)
            wflag_reg <= 1'b0;
      end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
      if (!ARST_N_IN)
         HRESP_OUT <= 1'b0;
      else
         HRESP_OUT <= 1'b0;

   assign HRDATA_OUT     = hrdata_reg;
   assign HREADYOUT_OUT  = hready_reg;
   assign WAKE_EVENT_OUT = wflag_reg;
   assign WAKE_IRQ_OUT   = wflag_reg;
   assign RTC_IRQ_OUT    = irq_reg;
endmodule // cca_rtc
`default_nettype wire

// *** tb/cca_rtc_sva.sv ***
/* Checker of the calendar clock bus, wake and interrupt outputs.
   Bound to cca_rtc and sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module cca_rtc_sva (
   input wire logic        CLK_IN, ARST_N_IN, CE_IN, LP_CLK_IN, SW_RESET_IN, HSEL_IN,
   input wire logic [31:0] HADDR_IN, HWDATA_IN, HRDATA_OUT,
   input wire logic [1:0]  HTRANS_IN,
   input wire logic [2:0]  HSIZE_IN,
   input wire logic        HWRITE_IN, HREADY_IN, HREADYOUT_OUT, HRESP_OUT,
   input wire logic        WAKE_EVENT_OUT, WAKE_IRQ_OUT, RTC_IRQ_OUT
);
   logic       acc;
   logic       rd_ph;
   logic       wr_ph;
   logic [5:0] a_ph;
   logic [3:0] lp_q;
   assign acc = HSEL_IN & HTRANS_IN[1] & HREADY_IN & CE_IN;
   // Data phase tracking; idle low-clock age saturates at 15
   always_ff @(posedge CLK_IN or negedge ARST_N_IN)
   begin
      if (!ARST_N_IN)
      begin
         rd_ph <= 1'b0;
         wr_ph <= 1'b0;
         a_ph  <= 6'h00;
         lp_q  <= 4'hF;
      end
      else if (CE_IN)
      begin
         rd_ph <= acc & ~HWRITE_IN;
         wr_ph <= acc & HWRITE_IN;
         a_ph  <= HADDR_IN[7:2];
         lp_q  <= LP_CLK_IN ? 4'h0 : lp_q + {3'h0, lp_q != 4'hF};
      end
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   chk_resp_okay:
      assert property (HRESP_OUT == 1'b0) else $error("error response");
   chk_wake_same:
      assert property (WAKE_IRQ_OUT == WAKE_EVENT_OUT) else $error("wake lines differ");
   chk_read_wait:
      assert property (acc && !HWRITE_IN |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
         else $error("read wait state wrong");
   chk_write_nowait:
      assert property (acc && HWRITE_IN |=> HREADYOUT_OUT) else $error("write stalled");
   chk_rdata_hold:
      assert property (!rd_ph |=> $stable(HRDATA_OUT)) else $error("read data moved");
   chk_wake_hold:
      assert property (WAKE_EVENT_OUT && !(rd_ph && a_ph == cca_pkg::A_WCLR[7:2])
         |=> WAKE_EVENT_OUT) else $error("wake dropped without clear read");
   chk_wake_readback:
      assert property (rd_ph && a_ph == cca_pkg::A_WCLR[7:2]
         |=> HRDATA_OUT[0] == $past(WAKE_EVENT_OUT)) else $error("clear read data wrong");
   chk_irq_disable:
      assert property (wr_ph && a_ph == cca_pkg::A_IDIS[7:2] && HWDATA_IN[8:0] == 9'h1FF
         |-> ##2 !RTC_IRQ_OUT) else $error("irq after full disable");
   chk_wake_tick:
      assert property ($rose(WAKE_EVENT_OUT) |-> lp_q < 4'hA) else $error("wake without tick");
endmodule // cca_rtc_sva
bind cca_rtc cca_rtc_sva cca_rtc_sva_i (.CLK_IN, .ARST_N_IN, .CE_IN, .LP_CLK_IN,
   .SW_RESET_IN, .HSEL_IN, .HADDR_IN, .HWDATA_IN, .HRDATA_OUT, .HTRANS_IN, .HSIZE_IN,
   .HWRITE_IN, .HREADY_IN, .HREADYOUT_OUT, .HRESP_OUT, .WAKE_EVENT_OUT, .WAKE_IRQ_OUT,
   .RTC_IRQ_OUT);
`default_nettype wire

// *** tb/tb_top.sv ***
/* Self-checking bench of the calendar clock.
   Drives the bus, low-power clock and software reset itself. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, lpc = 1'b0, swr = 1'b0, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
   logic        rdy, resp, wake, wirq, irq;
   int          bad_count = 0;
   int          n_tests = 0;
   always #10 clk = ~clk;
   cca_rtc cca_rtc_i (.CLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(1'b1), .LP_CLK_IN(lpc),
      .SW_RESET_IN(swr), .HSEL_IN(1'b1), .HADDR_IN(haddr), .HTRANS_IN(htrans),
      .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(rdy),
      .HRDATA_OUT(hrdata), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp),
      .WAKE_EVENT_OUT(wake), .WAKE_IRQ_OUT(wirq), .RTC_IRQ_OUT(irq));
   function automatic logic [31:0] tm(input int p, h, m, s, c);
      return {7'h0, p[0], h[4:0], m[5:0], s[5:0], c[6:0]};
   endfunction
   function automatic logic [31:0] cal(input int cn, y, mo, d, w);
      return {8'h0, cn[4:0], y[6:0], mo[3:0], d[4:0], w[2:0]};
   endfunction
   task automatic print_verdict;
      if (bad_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Ready is sampled where it is settled; the hang case is left to the watchdog
   task automatic wt;
      do @(negedge clk); while (rdy !== 1'b1);
      rdat = hrdata;
      @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      wt;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   task automatic lp(input int k);
      repeat (k)
      begin
         lpc <= 1'b1;
         repeat (4) @(posedge clk);
         lpc <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   initial
   begin
      int          cn[2] = '{20, 19};
      logic [31:0] ae[2] = '{32'h01, 32'h41};
      logic [31:0] r;
      void'($urandom(32'h4CD1));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(cca_pkg::A_CTRL, 32'h3);
      rd(cca_pkg::A_CAL, cal(19, 0, 1, 1, 1));
      rd(cca_pkg::A_DIV, 32'h0055_0147);
      rd(cca_pkg::A_DEN, 32'h3E8);
      rd(8'hFC, 32'h0);
      bus(1'b1, cca_pkg::A_CTRL, 32'h0);
      bus(1'b1, cca_pkg::A_TIME, 32'h0);
      lp(2);
      rd(cca_pkg::A_TIME, 32'h0);
      bus(1'b1, cca_pkg::A_DIV, 32'h8000_0001);
      lp(3);
      rd(cca_pkg::A_TIME, 32'h3);
      // Century years: only one divisible by four hundred is leap
      foreach (cn[i])
      begin
         bus(1'b1, cca_pkg::A_CAL, cal(cn[i], 0, 2, 28, 3));
         bus(1'b1, cca_pkg::A_TIME, tm(0, 23, 59, 59, 99));
         bus(1'b0, cca_pkg::A_EVT, 32'h0);
         lp(1);
         rd(cca_pkg::A_TIME, 32'h0);
         rd(cca_pkg::A_CAL, cal(cn[i], 0, 22 - cn[i], cn[i] == 20 ? 29 : 1, 4));
         bus(1'b0, cca_pkg::A_EVT, 32'h0);
         chk(rdat & 32'h1F7, cn[i] == 20 ? 32'h17 : 32'h57);
         rd(cca_pkg::A_EVT, 32'h0);
      end
      bus(1'b1, cca_pkg::A_CAL, cal(19, 99, 12, 31, 7));
      bus(1'b1, cca_pkg::A_TIME, tm(0, 23, 59, 59, 99));
      bus(1'b0, cca_pkg::A_EVT, 32'h0);
      lp(1);
      rd(cca_pkg::A_CAL, cal(20, 0, 1, 1, 1));
      rd(cca_pkg::A_EVT, 32'hF7);
      bus(1'b1, cca_pkg::A_CTRL, 32'h4);
      bus(1'b1, cca_pkg::A_TIME, tm(0, 11, 59, 59, 99));
      lp(1);
      rd(cca_pkg::A_TIME, tm(1, 12, 0, 0, 0));
      rd(cca_pkg::A_EVT, 32'hF);
      bus(1'b1, cca_pkg::A_CTRL, 32'h0);
      foreach (ae[i])
      begin
         bus(1'b1, cca_pkg::A_TIME, 32'h0);
         bus(1'b1, cca_pkg::A_ATIME, 32'h2);
         bus(1'b1, cca_pkg::A_AEN, ae[i]);
         bus(1'b0, cca_pkg::A_EVT, 32'h0);
         lp(3);
         rd(cca_pkg::A_EVT, 32'h100);
         rd(cca_pkg::A_AEN, ae[i][6] ? ae[i] : 32'h0);
      end
      bus(1'b1, cca_pkg::A_EVT, 32'h1);
      bus(1'b1, cca_pkg::A_IEN, 32'h3);
      rd(cca_pkg::A_IMSK, 32'h3);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, cca_pkg::A_IDIS, 32'h1);
      rd(cca_pkg::A_IMSK, 32'h2);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, cca_pkg::A_EVT, 32'h2);
      rd(cca_pkg::A_IMSK, 32'h2);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, cca_pkg::A_IDIS, 32'h1FF);
      rd(cca_pkg::A_IMSK, 32'h0);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, cca_pkg::A_WPER, 32'h3);
      bus(1'b1, cca_pkg::A_WCTL, 32'h1);
      lp(2);
      rd(cca_pkg::A_WCNT, 32'h1);
      chk({31'h0, wake}, 32'h0);
      lp(1);
      chk({30'h0, wirq, wake}, 32'h3);
      lp(2);
      rd(cca_pkg::A_WCNT, 32'h2);
      rd(cca_pkg::A_WCLR, 32'h1);
      chk({30'h0, wirq, wake}, 32'h0);
      bus(1'b1, cca_pkg::A_WCTL, 32'h0);
      lp(2);
      rd(cca_pkg::A_WCNT, 32'h2);
      repeat (4)
      begin
         r = tm(0, $urandom % 24, $urandom % 60, $urandom % 60, $urandom % 100);
         bus(1'b1, cca_pkg::A_TIME, r);
         rd(cca_pkg::A_TIME, r);
      end
      bus(1'b1, cca_pkg::A_KEEP, 32'h1);
      swr <= 1'b1;
      @(posedge clk);
      swr <= 1'b0;
      rd(cca_pkg::A_TIME, r);
      bus(1'b1, cca_pkg::A_KEEP, 32'h0);
      swr <= 1'b1;
      @(posedge clk);
      swr <= 1'b0;
      rd(cca_pkg::A_TIME, 32'h0);
      print_verdict;
   end
   initial
   begin
      #200000;
      bad_count++;
      print_verdict;
   end
endmodule // tb_top
`default_nettype wire
